// [common/cmd_pkg.sv]
package cmd_pkg;

  // ****************************************
  // Event status bit positions
  // ****************************************
  localparam int BIT_POWER_ON = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_CMD_ERR = 5;
  localparam int BIT_EXEC_ERR = 4;
  localparam int BIT_DEV_ERR = 3;
  localparam int BIT_QUERY_ERR = 2;
  localparam int BIT_REQ_CTRL = 1;
  localparam int BIT_OP_DONE = 0;
  localparam int STB_SUMMARY_BIT = 5;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] EVT_STAT_RST = 8'h80;
  localparam logic [7:0] EVT_EN_RST = 8'h00;
  localparam logic [7:0] SRQ_EN_RST = 8'h00;
  localparam logic [7:0] EVT_LIVE_MASK = 8'hbd;
  localparam logic [7:0] ERR_CNT_MAX = 8'hff;

  // ****************************************
  // Reply text
  // ****************************************
  localparam int RESP_MAX = 24;
  localparam int LEN_W = 5;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_TWO = 8'h32;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_COLON = 8'h3a;
  // Identity text, values arbitrary
  localparam int IDN_LEN = 20;
  localparam logic [8*IDN_LEN-1:0] IDN_TEXT = "MAKER,MDL1,SN0001,A1";
  localparam int HDR_LEN = 9;
  localparam logic [8*HDR_LEN-1:0] SETUP_RESTORE_HEADER = 72'h3a_53_59_53_54_3a_53_45_54;

  // ****************************************
  // Command and event carriers
  // ****************************************
  typedef enum logic [3:0] {
    CMD_NONE, CMD_CLR_STATUS, CMD_EVT_EN_WR, CMD_EVT_EN_RD, CMD_EVT_STAT_RD,
    CMD_IDENT_RD, CMD_LEARN_RD, CMD_OP_DONE, CMD_SRQ_EN_WR, CMD_SUBSYS
  } cmd_code_e;

  typedef struct packed {
    cmd_code_e code;
    logic [7:0] arg;
    logic compound;
  } cmd_s;

  typedef struct packed {
    logic cmd_err;
    logic exec_err;
    logic dev_err;
    logic query_err;
  } evt_s;

endpackage

// [core/dec_ascii.sv]
`timescale 1ns/1ps
`default_nettype none
module dec_ascii import cmd_pkg::*; (
  // Value in
  input wire logic [7:0] val,
  // Digits out
  output logic [7:0] hund,
  output logic [7:0] tens,
  output logic [7:0] ones,
  output logic [1:0] ndig
);
  logic [7:0] h;
  logic [7:0] t;
  logic [7:0] o;

  always_comb begin
    h = val / 8'd100;
    t = (val % 8'd100) / 8'd10;
    o = val % 8'd10;
    hund = CH_ZERO + h;
    tens = CH_ZERO + t;
    ones = CH_ZERO + o;
    if (h != 8'h00) begin
      ndig = 2'd3;
    end else if (t != 8'h00) begin
      ndig = 2'd2;
    end else begin
      ndig = 2'd1;
    end
  end
endmodule
`default_nettype wire

// [core/resp_ser.sv]
`timescale 1ns/1ps
`default_nettype none
module resp_ser import cmd_pkg::*; #(
  parameter int W = RESP_MAX
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Load side
  input wire logic load,
  input wire logic [LEN_W-1:0] len,
  input wire logic [8*W-1:0] data,
  output logic busy,
  // Byte stream
  input wire logic out_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last
);
  typedef enum logic {SER_IDLE, SER_SEND} ser_state_e;
  ser_state_e state_q, state_d;
  logic [8*W-1:0] data_q, data_d;
  logic [LEN_W-1:0] len_q, len_d, idx_q, idx_d;
  logic valid_q, valid_d, last_q, last_d;
  logic [7:0] byte_q, byte_d;

  always_comb begin
    state_d = state_q;
    data_d = data_q;
    len_d = len_q;
    idx_d = idx_q;
    valid_d = valid_q;
    last_d = last_q;
    byte_d = byte_q;
    case (state_q)
      SER_IDLE: begin
        if (load) begin
          data_d = data;
          len_d = len;
          idx_d = LEN_W'(1);
          byte_d = data[7:0];
          last_d = (len == LEN_W'(1));
          valid_d = 1'b1;
          state_d = SER_SEND;
        end
      end
      SER_SEND: begin
        if (out_ready) begin
          if (last_q) begin
            valid_d = 1'b0;
            last_d = 1'b0;
            state_d = SER_IDLE;
          end else begin
            byte_d = data_q[8*idx_q +: 8];
            idx_d = idx_q + LEN_W'(1);
            last_d = (idx_q + LEN_W'(1) == len_q);
          end
        end
      end
      default: state_d = SER_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= SER_IDLE;
      data_q <= '0;
      len_q <= '0;
      idx_q <= '0;
      valid_q <= 1'b0;
      last_q <= 1'b0;
      byte_q <= 8'h00;
    end else begin
      state_q <= state_d;
      data_q <= data_d;
      len_q <= len_d;
      idx_q <= idx_d;
      valid_q <= valid_d;
      last_q <= last_d;
      byte_q <= byte_d;
    end
  end

  assign busy = (state_q == SER_SEND);
  assign out_valid = valid_q;
  assign out_data = byte_q;
  assign out_last = last_q;
endmodule
`default_nettype wire

// [core/common_cmd_status.sv]
`timescale 1ns/1ps
`default_nettype none
module common_cmd_status import cmd_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Parsed commands
  input wire logic cmd_valid,
  input wire cmd_s cmd,
  // Device events
  input wire evt_s evt,
  input wire logic ops_pending,
  // Reply stream
  input wire logic out_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  // Status view
  output logic [7:0] status_byte,
  output logic srq_summary,
  output logic [3:0] subsys,
  output logic [7:0] err_count
);
  // ****************************************
  // State
  // ****************************************
  logic [7:0] evt_stat_q, evt_stat_d;
  logic [7:0] evt_en_q, evt_en_d;
  logic [7:0] srq_en_q, srq_en_d;
  logic [3:0] subsys_q, subsys_d;
  logic [7:0] err_cnt_q, err_cnt_d;
  logic opc_arm_q, opc_arm_d;
  logic summary_q, summary_d;
  logic srq_q, srq_d;
  logic [7:0] stb_d;
  logic [7:0] set_bits;
  logic [2:0] err_new;
  logic is_query, do_reply, do_cls, do_stat_rd;
  logic ser_busy;
  logic [7:0] dec_val, d_h, d_t, d_o;
  logic [1:0] d_n;
  logic [7:0] rb [RESP_MAX];
  logic [8*RESP_MAX-1:0] rflat;
  logic [LEN_W-1:0] rlen;
  int p;

  // ****************************************
  // Command decode
  // ****************************************
  always_comb begin
    // Accepted regardless of the compound flag
    is_query = cmd_valid && (cmd.code == CMD_EVT_EN_RD || cmd.code == CMD_EVT_STAT_RD ||
               cmd.code == CMD_IDENT_RD || cmd.code == CMD_LEARN_RD);
    do_reply = is_query && !ser_busy;
    do_cls = cmd_valid && (cmd.code == CMD_CLR_STATUS);
    do_stat_rd = do_reply && (cmd.code == CMD_EVT_STAT_RD);
  end

  // ****************************************
  // Event status and enables
  // ****************************************
  always_comb begin
    set_bits = 8'h00;
    set_bits[BIT_CMD_ERR] = evt.cmd_err;
    set_bits[BIT_EXEC_ERR] = evt.exec_err;
    set_bits[BIT_DEV_ERR] = evt.dev_err;
    set_bits[BIT_QUERY_ERR] = evt.query_err || (is_query && ser_busy);
    set_bits[BIT_OP_DONE] = opc_arm_q && !ops_pending;
    opc_arm_d = opc_arm_q;
    if (opc_arm_q && !ops_pending) begin
      opc_arm_d = 1'b0;
    end
    if (cmd_valid && cmd.code == CMD_OP_DONE) begin
      opc_arm_d = 1'b1;
    end
    if (do_cls) begin
      opc_arm_d = 1'b0;
    end
    // Clear by status read or clear command, new events win
    evt_stat_d = ((do_cls || do_stat_rd) ? 8'h00 : evt_stat_q) | set_bits;
    evt_stat_d = evt_stat_d & EVT_LIVE_MASK;
    evt_en_d = evt_en_q;
    if (cmd_valid && cmd.code == CMD_EVT_EN_WR) begin
      evt_en_d = cmd.arg & EVT_LIVE_MASK;
    end
    srq_en_d = srq_en_q;
    if (cmd_valid && cmd.code == CMD_SRQ_EN_WR) begin
      srq_en_d = cmd.arg;
    end
    // Subsystem only moves on a subsystem command
    subsys_d = subsys_q;
    if (cmd_valid && cmd.code == CMD_SUBSYS) begin
      subsys_d = cmd.arg[3:0];
    end
    err_new = 3'(evt.cmd_err) + 3'(evt.exec_err) + 3'(evt.dev_err) + 3'(evt.query_err);
    if (do_cls) begin
      err_cnt_d = 8'(err_new);
    end else if (err_cnt_q > ERR_CNT_MAX - 8'(err_new)) begin
      err_cnt_d = ERR_CNT_MAX;
    end else begin
      err_cnt_d = err_cnt_q + 8'(err_new);
    end
    summary_d = |(evt_stat_d & evt_en_d);
    stb_d = 8'h00;
    stb_d[STB_SUMMARY_BIT] = summary_d;
    srq_d = |(stb_d & srq_en_d);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evt_stat_q <= EVT_STAT_RST;
      evt_en_q <= EVT_EN_RST;
      srq_en_q <= SRQ_EN_RST;
      subsys_q <= 4'h0;
      err_cnt_q <= 8'h00;
      opc_arm_q <= 1'b0;
      summary_q <= 1'b0;
      srq_q <= 1'b0;
    end else begin
      evt_stat_q <= evt_stat_d;
      evt_en_q <= evt_en_d;
      srq_en_q <= srq_en_d;
      subsys_q <= subsys_d;
      err_cnt_q <= err_cnt_d;
      opc_arm_q <= opc_arm_d;
      summary_q <= summary_d;
      srq_q <= srq_d;
    end
  end

  // ****************************************
  // Reply build
  // ****************************************
  assign dec_val = (cmd.code == CMD_EVT_EN_RD) ? evt_en_q : evt_stat_q;

  dec_ascii u_dec (
    .val(dec_val),
    .hund(d_h),
    .tens(d_t),
    .ones(d_o),
    .ndig(d_n)
  );

  always_comb begin
    p = 0;
    for (int i = 0; i < RESP_MAX; i++) begin
      rb[i] = 8'h00;
    end
    // Only the setup block reply carries a command header
    case (cmd.code)
      CMD_EVT_EN_RD, CMD_EVT_STAT_RD: begin
        if (cmd.code == CMD_EVT_EN_RD) begin
          rb[p] = CH_PLUS;
          p = p + 1;
        end
        if (d_n == 2'd3) begin
          rb[p] = d_h;
          p = p + 1;
        end
        if (d_n != 2'd1) begin
          rb[p] = d_t;
          p = p + 1;
        end
        rb[p] = d_o;
        rb[p + 1] = CH_NL;
        p = p + 2;
      end
      CMD_IDENT_RD: begin
        for (int i = 0; i < IDN_LEN; i++) begin
          rb[i] = IDN_TEXT[8*(IDN_LEN-1-i) +: 8];
        end
        rb[IDN_LEN] = CH_NL;
        p = IDN_LEN + 1;
      end
      CMD_LEARN_RD: begin
        for (int i = 0; i < HDR_LEN; i++) begin
          rb[i] = SETUP_RESTORE_HEADER[8*(HDR_LEN-1-i) +: 8];
        end
        rb[HDR_LEN] = CH_HASH;
        rb[HDR_LEN + 1] = CH_ONE;
        rb[HDR_LEN + 2] = CH_TWO;
        rb[HDR_LEN + 3] = evt_en_q;
        rb[HDR_LEN + 4] = srq_en_q;
        rb[HDR_LEN + 5] = CH_NL;
        p = HDR_LEN + 6;
      end
      default: p = 1;
    endcase
    rlen = LEN_W'(p);
    for (int i = 0; i < RESP_MAX; i++) begin
      rflat[8*i +: 8] = rb[i];
    end
  end

  resp_ser #(.W(RESP_MAX)) u_ser (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(do_reply),
    .len(rlen),
    .data(rflat),
    .busy(ser_busy),
    .out_ready(out_ready),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_last(out_last)
  );

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    status_byte = 8'h00;
    status_byte[STB_SUMMARY_BIT] = summary_q;
  end
  assign srq_summary = srq_q;
  assign subsys = subsys_q;
  assign err_count = err_cnt_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_op_cmd;
    cmd_valid && cmd.code == CMD_OP_DONE && !do_cls;
  endsequence
  sequence s_ops_idle;
    !ops_pending && !do_cls;
  endsequence

  a_unused_zero: assert property (!evt_stat_q[BIT_UNUSED] && !evt_en_q[BIT_UNUSED])
    else $error("unused event bit set");
  a_req_ctrl_zero: assert property (!evt_stat_q[BIT_REQ_CTRL])
    else $error("request control bit set");
  a_enable_load: assert property (cmd_valid && cmd.code == CMD_EVT_EN_WR
    |=> evt_en_q == ($past(cmd.arg) & EVT_LIVE_MASK))
    else $error("event enable not loaded");
  a_summary_track: assert property (status_byte[STB_SUMMARY_BIT] == |(evt_stat_q & evt_en_q))
    else $error("summary bit mismatch");
  a_clear_status: assert property (do_cls && set_bits == 8'h00 && err_new == 3'd0
    |=> evt_stat_q == 8'h00 && err_cnt_q == 8'h00)
    else $error("clear status incomplete");
  a_read_clears: assert property (do_stat_rd && set_bits == 8'h00
    |=> evt_stat_q == 8'h00 && out_valid)
    else $error("status read did not clear");
  a_cmd_err_set: assert property (evt.cmd_err |=> evt_stat_q[BIT_CMD_ERR])
    else $error("command error not flagged");
  a_exec_err_set: assert property (evt.exec_err |=> evt_stat_q[BIT_EXEC_ERR])
    else $error("execution error not flagged");
  a_dev_err_set: assert property (evt.dev_err |=> evt_stat_q[BIT_DEV_ERR])
    else $error("device error not flagged");
  a_busy_query: assert property (is_query && ser_busy |=> evt_stat_q[BIT_QUERY_ERR])
    else $error("query error not flagged");
  a_op_done_set: assert property (s_op_cmd ##1 s_ops_idle |=> evt_stat_q[BIT_OP_DONE])
    else $error("operation complete not set");
  a_subsys_hold: assert property (cmd_valid && cmd.code != CMD_SUBSYS |=> $stable(subsys_q))
    else $error("subsystem changed");
  a_enable_plus: assert property (do_reply && cmd.code == CMD_EVT_EN_RD
    |=> out_valid && out_data == CH_PLUS)
    else $error("enable reply lacks plus");
  a_learn_prefix: assert property (do_reply && cmd.code == CMD_LEARN_RD
    |=> out_valid && out_data == CH_COLON)
    else $error("learn reply lacks prefix");

  sequence s_ops_busy;
    ops_pending && !do_cls;
  endsequence
  a_power_on_bit: assert property ($past(rst) |-> evt_stat_q[BIT_POWER_ON])
    else $error("power on bit missing");
  a_power_on_blocked: assert property ($past(rst) |-> evt_en_q == 8'h00 && !status_byte[STB_SUMMARY_BIT])
    else $error("summary set out of reset");
  a_query_err_set: assert property (evt.query_err |=> evt_stat_q[BIT_QUERY_ERR])
    else $error("query error not flagged");
  a_srq_track: assert property (srq_summary ==
    (status_byte[STB_SUMMARY_BIT] && srq_en_q[STB_SUMMARY_BIT]))
    else $error("service summary mismatch");
  a_srq_en_load: assert property (cmd_valid && cmd.code == CMD_SRQ_EN_WR
    |=> srq_en_q == $past(cmd.arg))
    else $error("service enable not loaded");
  a_subsys_load: assert property (cmd_valid && cmd.code == CMD_SUBSYS
    |=> subsys_q == $past(cmd.arg[3:0]))
    else $error("subsystem not selected");
  a_summary_drop: assert property ((do_cls || do_stat_rd) && set_bits == 8'h00
    |=> !status_byte[STB_SUMMARY_BIT])
    else $error("summary kept after clear");
  a_compound_cls: assert property (do_cls && cmd.compound && set_bits == 8'h00
    |=> evt_stat_q == 8'h00)
    else $error("compound clear ignored");
  a_stat_digit: assert property (do_stat_rd && evt_stat_q < 8'd10
    |=> out_valid && out_data == CH_ZERO + $past(evt_stat_q))
    else $error("status reply digit wrong");
  a_ident_first: assert property (do_reply && cmd.code == CMD_IDENT_RD
    |=> out_valid && out_data == IDN_TEXT[8*IDN_LEN-1 -: 8])
    else $error("identity reply wrong start");
  a_reply_newline: assert property (out_valid && out_last |-> out_data == CH_NL)
    else $error("reply not ended by newline");
  a_no_header: assert property (do_reply && cmd.code != CMD_LEARN_RD |=> out_data != CH_COLON)
    else $error("query reply carries header");
  a_op_done_armed: assert property (s_op_cmd ##1 s_ops_busy |=> opc_arm_q)
    else $error("operation complete not armed");
  a_err_record: assert property (!do_cls && err_new != 3'd0 && err_cnt_q < ERR_CNT_MAX
    |=> err_cnt_q > $past(err_cnt_q))
    else $error("error record not counted");
endmodule
`default_nettype wire

// [sim/host_sink.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************
// Host reply sink
// ********************
module host_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pacing
  input wire logic slow,
  // Reply stream
  input wire logic out_valid,
  output logic out_ready
);
  logic [3:0] lfsr_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lfsr_q <= 4'h9;
    end else begin
      lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
    end
  end
  // Stalls in a pattern when slow
  assign out_ready = !slow || (out_valid && lfsr_q[0]);
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb import cmd_pkg::*; ;
  logic clk_sys, rst, cmd_valid, ops_pending, out_ready, out_valid, out_last, srq_summary, slow, rx_done;
  cmd_s cmd;
  evt_s evt;
  evt_s e;
  logic [7:0] out_data, status_byte, err_count, en_m, stat_m, srq_m, v, w;
  logic [3:0] subsys;
  logic [7:0] rxq[$];
  logic [7:0] expq[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed;

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  common_cmd_status uut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .evt(evt),
    .ops_pending(ops_pending), .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .status_byte(status_byte), .srq_summary(srq_summary), .subsys(subsys),
    .err_count(err_count));
  host_sink host (.clk_sys(clk_sys), .rst(rst), .slow(slow), .out_valid(out_valid), .out_ready(out_ready));

  // ********************
  // Capture and helpers
  // ********************
  always @(posedge clk_sys) begin
    cycles++;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      rxq.push_back(out_data);
      if (out_last === 1'b1) begin
        rx_done = 1'b1;
      end
    end
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic send(input cmd_code_e c, input logic [7:0] a, input logic p);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd = '{code: c, arg: a, compound: p};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd = '{code: CMD_NONE, arg: 8'h00, compound: 1'b0};
  endtask

  task automatic pulse(input evt_s x);
    @(negedge clk_sys);
    evt = x;
    @(negedge clk_sys);
    evt = '0;
  endtask

  task automatic start_q(input cmd_code_e c);
    rxq.delete();
    rx_done = 1'b0;
    send(c, 8'h00, 1'b0);
  endtask

  task automatic finish_q();
    int i;
    i = 0;
    while (rx_done !== 1'b1 && i < 400) begin
      @(negedge clk_sys);
      i++;
    end
    chk(rxq.size(), expq.size());
    foreach (expq[k]) begin
      chk(rxq[k], expq[k]);
    end
    expq.delete();
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic num_exp(input int n, input bit plus);
    if (plus) begin
      expq.push_back(CH_PLUS);
    end
    if (n >= 100) begin
      expq.push_back(8'(48 + n / 100));
    end
    if (n >= 10) begin
      expq.push_back(8'(48 + (n / 10) % 10));
    end
    expq.push_back(8'(48 + n % 10));
    expq.push_back(CH_NL);
  endtask

  function automatic logic [7:0] sb_exp();
    return {2'b00, |(stat_m & en_m), 5'b00000};
  endfunction

  task automatic set_en(input logic [7:0] m, input logic p);
    send(CMD_EVT_EN_WR, m, p);
    en_m = m & 8'hbd;
  endtask

  task automatic esr_q();
    start_q(CMD_EVT_STAT_RD);
    num_exp(stat_m, 1'b0);
    finish_q();
    stat_m = 8'h00;
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    seed = 51;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '{code: CMD_NONE, arg: 8'h00, compound: 1'b0};
    evt = '0;
    ops_pending = 1'b0;
    slow = 1'b0;
    en_m = 8'h00;
    stat_m = 8'h80;
    srq_m = 8'h00;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    chk(status_byte, 8'h00);
    chk(out_valid, 1'b0);
    esr_q();
    esr_q();
    // Mask write and read-back
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      slow = i[0];
      set_en(v, 1'b0);
      start_q(CMD_EVT_EN_RD);
      num_exp(en_m, 1'b1);
      finish_q();
    end
    send(CMD_SRQ_EN_WR, 8'h20, 1'b0);
    srq_m = 8'h20;
    // Each error event, blocked then passed
    for (int i = 0; i < 4; i++) begin
      e = evt_s'(4'b1000 >> i);
      w = 8'h20 >> i;
      send(CMD_CLR_STATUS, 8'h00, 1'b0);
      stat_m = 8'h00;
      set_en(~w, 1'b0);
      pulse(e);
      stat_m = stat_m | w;
      @(negedge clk_sys);
      chk(status_byte, sb_exp());
      set_en(w, 1'b0);
      repeat (2) @(negedge clk_sys);
      chk(status_byte, sb_exp());
      chk(srq_summary, |(sb_exp() & srq_m));
      esr_q();
      chk(status_byte, 8'h00);
    end
    send(CMD_CLR_STATUS, 8'h00, 1'b0);
    chk(err_count, 8'h00);
    pulse(evt_s'(4'b1000));
    @(negedge clk_sys);
    chk(err_count, 8'h01);
    send(CMD_CLR_STATUS, 8'h00, 1'b0);
    @(negedge clk_sys);
    chk(err_count, 8'h00);
    stat_m = 8'h00;
    // Completion waits for pending work
    set_en(8'h01, 1'b0);
    ops_pending = 1'b1;
    send(CMD_OP_DONE, 8'h00, 1'b0);
    repeat (4) @(negedge clk_sys);
    chk(status_byte, 8'h00);
    ops_pending = 1'b0;
    repeat (3) @(negedge clk_sys);
    stat_m = 8'h01;
    chk(status_byte, sb_exp());
    esr_q();
    send(CMD_OP_DONE, 8'h00, 1'b0);
    repeat (2) @(negedge clk_sys);
    stat_m = 8'h01;
    chk(status_byte, sb_exp());
    esr_q();
    // Selected subsystem survives common commands
    send(CMD_SUBSYS, 8'h03, 1'b0);
    send(CMD_CLR_STATUS, 8'h00, 1'b1);
    set_en(8'h10, 1'b1);
    chk(subsys, 4'h3);
    start_q(CMD_EVT_EN_RD);
    num_exp(en_m, 1'b1);
    finish_q();
    // Identity with a refused overlapping query
    slow = 1'b1;
    start_q(CMD_IDENT_RD);
    send(CMD_EVT_EN_RD, 8'h00, 1'b0);
    for (int k = 0; k < IDN_LEN; k++) begin
      expq.push_back(IDN_TEXT[8 * (IDN_LEN - 1 - k) +: 8]);
    end
    expq.push_back(CH_NL);
    finish_q();
    stat_m = 8'h04;
    esr_q();
    // Setup block
    start_q(CMD_LEARN_RD);
    for (int k = 0; k < HDR_LEN; k++) begin
      expq.push_back(SETUP_RESTORE_HEADER[8 * (HDR_LEN - 1 - k) +: 8]);
    end
    expq.push_back(CH_HASH);
    expq.push_back(CH_ONE);
    expq.push_back(CH_TWO);
    expq.push_back(en_m);
    expq.push_back(srq_m);
    expq.push_back(CH_NL);
    finish_q();
    chk(rxq.size(), HDR_LEN + 6);
    close_out();
  end
endmodule
`default_nettype wire
